//--- rtl/oct_ctrl.sv
// Oscillator control registers with automatic tuning engine
// Notes on behaviour
// - Tuning enabled: engine drives trim; disabled: trim comes only from software.
// - Enabled with hold set: engine stops writing trim; clear resumes updates.
// - Disabled with hold set: software trim writes blocked; clear lets them through.
// - Lock flag is 1 only within one percent of nominal; resets to 0.
// - Out-of-range flag is 1 when needed trim exceeds trim range; resets to 0.
// - Read-only 3-bit field shows current system clock source code.
// - Power select bit: 1 high-power, 0 low-power secondary oscillator.
// - Signed 6-bit trim: 0x1f max, 0x00 centre default, 0x20 minimum.
// - Range codes 000..101 give 1..32 MHz; 110 and 111 reserved.
// - Ready flags read 1 when oscillator ready, 0 when off or not ready.
// - Fast oscillator force bit keeps it on at the selected range.
// - Medium, slow and converter RC force bits keep those oscillators on.
// - Secondary force bit keeps it on in the selected power mode.
// - While tuning enabled, software trim writes are discarded.
// - Out of range keeps last trim; flag clears once tunable again.
// - Enabled: lock or range flag change sets event flag; trim steps do not.
// - Writing range select clears fast ready until the new range settles.
`default_nettype none
module oct_ctrl #(
   parameter int WIN_REFS      = oct_pkg::WIN_REFS_DEF,
   parameter int TICK_DIV      = oct_pkg::TICK_DIV_DEF,
   parameter int SETTLE_CYCLES = oct_pkg::SETTLE_CYCLES
) (
   input  wire logic       clk_sys_in,
   input  wire logic       sys_rst_in,
   input  wire logic [11:0] addr_in,
   input  wire logic [7:0] wr_data_in,
   input  wire logic       wr_en_in,
   input  wire logic       rd_en_in,
   output var  logic [7:0] rd_data_out,
   input  wire logic       ref_clk_in,
   input  wire logic       fast_osc_tick_in,
   input  wire logic [5:0] osc_ready_in,
   input  wire logic [2:0] current_source_code_in,
   output var  logic [5:0] freq_trim_field_out,
   output var  logic [2:0] fast_osc_range_select_out,
   output var  logic [4:0] force_on_out,
   output var  logic       secondary_osc_high_power_out,
   output var  logic       tuning_irq_out
);
   localparam int CNT_W = 18;
   localparam int WIN_W = $clog2(WIN_REFS);
   localparam int SET_W = $clog2(SETTLE_CYCLES + 1);

   typedef struct packed {
      logic             ref_s1;
      logic             ref_s2;
      logic             ref_d;
      logic             tick_s1;
      logic             tick_s2;
      logic             tick_d;
      logic [5:0]       rdy_s1;
      logic [5:0]       rdy_s2;
      logic [2:0]       src_s1;
      logic [2:0]       src_s2;
      logic             tune_en;
      logic             upd_hold;
      logic             locked;
      logic             oor;
      logic             high_pwr;
      logic [4:0]       force_on;
      logic [5:0]       trim;
      logic [2:0]       range;
      logic             settling;
      logic [SET_W-1:0] settle_cnt;
      logic             primed;
      logic [WIN_W-1:0] win_cnt;
      logic [CNT_W-1:0] tick_cnt;
      logic             evt_flag;
      logic             evt_en;
      logic [7:0]       rd_data;
      logic             irq;
   } oct_state_s;

   oct_state_s st;
   oct_state_s next_st;

   // Expected divided-tick count per window for a range code
   function automatic logic [CNT_W-1:0] oct_expected(input logic [2:0] code);
      longint f;
      begin
         f = longint'(oct_pkg::BASE_FREQ_HZ) << code;
         oct_expected = CNT_W'((f / TICK_DIV) * WIN_REFS / oct_pkg::REF_FREQ_HZ);
      end
   endfunction

   // Address match for a write cycle
   function automatic logic oct_wr_hit(input logic [11:0] a, input logic we,
                                       input logic [11:0] target);
      oct_wr_hit = we && (a == target);
   endfunction

   // Next-state logic
   always_comb
   begin
      logic [CNT_W-1:0] expected;
      logic [CNT_W-1:0] err_mag;
      logic             too_fast;
      logic             new_lock;
      logic             new_oor;
      logic             win_end;
      logic             ref_edge;
      logic             tick_edge;
      logic             evt_set;
      logic [7:0]       rd_mux;
      logic [31:0]      err_pct;
      logic [31:0]      tol_pct;
      logic [31:0]      err_pml;
      logic [31:0]      tol_pml;
      logic             lock_chg;
      logic             oor_chg;
      logic             hit_ctrl;
      logic             hit_pwr;
      logic             hit_force;
      logic             hit_trim;
      logic             hit_range;
      logic             hit_ien;
      logic             hit_clr;
      logic             sw_trim_ok;
      logic             range_ok;

      // Locals start at zero so no path infers a latch
      expected  = '0;
      err_mag   = '0;
      too_fast  = 1'b0;
      new_lock  = 1'b0;
      new_oor   = 1'b0;
      win_end   = 1'b0;
      evt_set   = 1'b0;
      rd_mux    = 8'h00;
      ref_edge  = 1'b0;
      tick_edge = 1'b0;
      err_pct   = '0;
      tol_pct   = '0;
      err_pml   = '0;
      tol_pml   = '0;
      lock_chg  = 1'b0;
      oor_chg   = 1'b0;

      // Write decode, one strobe per register
      hit_ctrl   = oct_wr_hit(addr_in, wr_en_in, oct_pkg::ADDR_TUNING_CTRL);
      hit_pwr    = oct_wr_hit(addr_in, wr_en_in, oct_pkg::ADDR_SEC_POWER);
      hit_force  = oct_wr_hit(addr_in, wr_en_in, oct_pkg::ADDR_FORCE_ENABLE);
      hit_trim   = oct_wr_hit(addr_in, wr_en_in, oct_pkg::ADDR_FREQ_TRIM);
      hit_range  = oct_wr_hit(addr_in, wr_en_in, oct_pkg::ADDR_FREQ_SELECT);
      hit_ien    = oct_wr_hit(addr_in, wr_en_in, oct_pkg::ADDR_IRQ_ENABLE);
      hit_clr    = oct_wr_hit(addr_in, wr_en_in, oct_pkg::ADDR_IRQ_CLEAR);
      // Software owns the trim only with the engine off and hold clear
      sw_trim_ok = !st.tune_en && !st.upd_hold;
      range_ok   = wr_data_in[oct_pkg::RANGE_W-1:0] <= oct_pkg::RANGE_MAX_CODE;
      next_st   = st;

      // Two-flop synchronisers for pin-side inputs
      next_st.ref_s1  = ref_clk_in;
      next_st.ref_s2  = st.ref_s1;
      next_st.ref_d   = st.ref_s2;
      next_st.tick_s1 = fast_osc_tick_in;
      next_st.tick_s2 = st.tick_s1;
      next_st.tick_d  = st.tick_s2;
      next_st.rdy_s1  = osc_ready_in;
      next_st.rdy_s2  = st.rdy_s1;
      next_st.src_s1  = current_source_code_in;
      next_st.src_s2  = st.src_s1;
      ref_edge  = st.ref_s2 & ~st.ref_d;
      tick_edge = st.tick_s2 & ~st.tick_d;

      // Settling countdown after a range change
      if (st.settling)
      begin
         if (st.settle_cnt == '0)
            next_st.settling = 1'b0;
         else
            next_st.settle_cnt = st.settle_cnt - 1'b1;
      end

      // Tuning engine: count fast ticks over a window of reference edges
      if (!st.tune_en || st.settling)
      begin
         // Partial windows would mislead the measurement, so restart
         next_st.primed   = 1'b0;
         next_st.win_cnt  = '0;
         next_st.tick_cnt = '0;
      end
      else
      begin
         if (tick_edge && (st.tick_cnt != '1))
            next_st.tick_cnt = st.tick_cnt + 1'b1; // Saturates on a runaway clock
         if (ref_edge)
         begin
            if (!st.primed)
            begin
               next_st.primed   = 1'b1;
               next_st.win_cnt  = '0;
               next_st.tick_cnt = '0;
            end
            else if (st.win_cnt == WIN_W'(WIN_REFS - 1))
            begin
               win_end          = 1'b1;
               next_st.win_cnt  = '0;
               next_st.tick_cnt = '0;
            end
            else
               next_st.win_cnt = st.win_cnt + 1'b1;
         end
      end

      // Window evaluation: lock, range and trim step
      if (win_end)
      begin
         expected = oct_expected(st.range);
         too_fast = st.tick_cnt > expected;
         err_mag  = too_fast ? st.tick_cnt - expected : expected - st.tick_cnt;
         // Scaled in 32 bits; an 18-bit product would wrap on a big error
         err_pct  = 32'(err_mag) * 32'h64; // Percent
         tol_pct  = 32'(expected) * 32'(oct_pkg::LOCK_TOL_PCT);
         err_pml  = 32'(err_mag) * 32'h3e8; // Per mille
         tol_pml  = 32'(expected) * 32'(oct_pkg::STEP_BAND_PERMILLE);
         new_lock = (err_pct <= tol_pct);
         new_oor  = st.oor;
         if (err_pml > tol_pml)
         begin
            // Out of range holds the last trim value
            if (too_fast && st.trim == oct_pkg::TRIM_MIN)
               new_oor = 1'b1;
            else if (!too_fast && st.trim == oct_pkg::TRIM_MAX)
               new_oor = 1'b1;
            else
            begin
               new_oor = 1'b0;
               if (!st.upd_hold)
                  next_st.trim = too_fast ? st.trim - 6'h01 : st.trim + 6'h01;
            end
         end
         else
            new_oor = 1'b0;
         // Status flags and the event they raise
         lock_chg       = new_lock != st.locked;
         oor_chg        = new_oor != st.oor;
         next_st.locked = new_lock;
         next_st.oor    = new_oor;
         if (lock_chg || oor_chg)
            evt_set = 1'b1;
      end

      // Disabling the engine drops both status flags without an event
      if (!st.tune_en)
      begin
         next_st.locked = 1'b0;
         next_st.oor    = 1'b0;
      end

      // Register writes
      if (hit_ctrl)
      begin
         next_st.tune_en  = wr_data_in[oct_pkg::BIT_TUNE_EN];
         next_st.upd_hold = wr_data_in[oct_pkg::BIT_UPD_HOLD];
      end
      if (hit_pwr)
         next_st.high_pwr = wr_data_in[oct_pkg::BIT_HIGH_PWR];
      if (hit_force)
         next_st.force_on = wr_data_in[oct_pkg::FORCE_LSB +: 5];
      // Software trim only when engine off and hold clear
      if (hit_trim && sw_trim_ok)
         next_st.trim = wr_data_in[oct_pkg::TRIM_W-1:0];
      // Reserved range codes are ignored to keep the oscillator legal
      if (hit_range && range_ok)
      begin
         next_st.range      = wr_data_in[oct_pkg::RANGE_W-1:0];
         next_st.settling   = 1'b1;
         next_st.settle_cnt = SET_W'(SETTLE_CYCLES - 1);
      end
      if (hit_ien)
         next_st.evt_en = wr_data_in[oct_pkg::BIT_EVT];

      // Sticky event flag: a new event beats a clear in the same cycle
      if (hit_clr && wr_data_in[oct_pkg::BIT_EVT])
         next_st.evt_flag = 1'b0;
      if (evt_set)
         next_st.evt_flag = 1'b1;
      // Interrupt level registered beside the flag it follows
      next_st.irq = next_st.evt_flag & next_st.evt_en;

      // Read mux, data stands the cycle after the strobe only
      case (addr_in)
         oct_pkg::ADDR_SRC_READBACK:
            rd_mux[oct_pkg::SRC_LSB +: 3] = st.src_s2;
         oct_pkg::ADDR_SEC_POWER:
            rd_mux[oct_pkg::BIT_HIGH_PWR] = st.high_pwr;
         oct_pkg::ADDR_READY_FLAGS:
         begin
            rd_mux[oct_pkg::READY_LSB +: 6] = st.rdy_s2;
            rd_mux[oct_pkg::READY_LSB + 5]  = st.rdy_s2[5] & ~st.settling;
         end
         oct_pkg::ADDR_FORCE_ENABLE:
            rd_mux[oct_pkg::FORCE_LSB +: 5] = st.force_on;
         oct_pkg::ADDR_FREQ_TRIM:
            rd_mux[oct_pkg::TRIM_W-1:0] = st.trim;
         oct_pkg::ADDR_FREQ_SELECT:
            rd_mux[oct_pkg::RANGE_W-1:0] = st.range;
         oct_pkg::ADDR_TUNING_CTRL:
         begin
            rd_mux[oct_pkg::BIT_TUNE_EN]  = st.tune_en;
            rd_mux[oct_pkg::BIT_UPD_HOLD] = st.upd_hold;
            rd_mux[oct_pkg::BIT_LOCKED]   = st.locked;
            rd_mux[oct_pkg::BIT_OOR]      = st.oor;
         end
         oct_pkg::ADDR_IRQ_STATUS:
            rd_mux[oct_pkg::BIT_EVT] = st.evt_flag;
         oct_pkg::ADDR_IRQ_ENABLE:
            rd_mux[oct_pkg::BIT_EVT] = st.evt_en;
         default:
            rd_mux = 8'h00;
      endcase
      // Idle cycles return zero so stale data never lingers
      next_st.rd_data = rd_en_in ? rd_mux : 8'h00;
   end

   // State register
   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
      begin
         st          <= '0;
         // Fields with a package reset code
         st.trim     <= oct_pkg::TRIM_RESET;
         st.range    <= oct_pkg::RANGE_RESET;
         st.force_on <= oct_pkg::FORCE_RESET;
      end
      else
         st <= next_st;
   end

   // Outputs straight from the state flops
   assign rd_data_out                  = st.rd_data;
   assign freq_trim_field_out          = st.trim;
   assign fast_osc_range_select_out    = st.range;
   assign force_on_out                 = st.force_on;
   assign secondary_osc_high_power_out = st.high_pwr;
   assign tuning_irq_out               = st.irq;
endmodule
`default_nettype wire

//--- rtl/oct_pkg.sv
// Package: register map, field positions, reset values and timing for oscillator control
`default_nettype none
package oct_pkg;
   // Register addresses
   localparam logic [11:0] ADDR_SRC_READBACK = 12'h20e;
   localparam logic [11:0] ADDR_SEC_POWER    = 12'h20f;
   localparam logic [11:0] ADDR_READY_FLAGS  = 12'h210;
   localparam logic [11:0] ADDR_FORCE_ENABLE = 12'h211;
   localparam logic [11:0] ADDR_FREQ_TRIM    = 12'h212;
   localparam logic [11:0] ADDR_FREQ_SELECT  = 12'h213;
   localparam logic [11:0] ADDR_TUNING_CTRL  = 12'h214;
   localparam logic [11:0] ADDR_IRQ_STATUS   = 12'h215;
   localparam logic [11:0] ADDR_IRQ_CLEAR    = 12'h216;
   localparam logic [11:0] ADDR_IRQ_ENABLE   = 12'h217;

   // Field positions
   localparam int BIT_TUNE_EN    = 7;
   localparam int BIT_UPD_HOLD   = 6;
   localparam int BIT_LOCKED     = 3;
   localparam int BIT_OOR        = 1;
   localparam int SRC_LSB        = 4;
   localparam int BIT_HIGH_PWR   = 6;
   localparam int READY_LSB      = 1;
   localparam int FORCE_LSB      = 2;
   localparam int TRIM_W         = 6;
   localparam int RANGE_W        = 3;
   localparam int BIT_EVT        = 0;

   // Reset values
   localparam logic [5:0] TRIM_RESET  = 6'h00;
   localparam logic [2:0] RANGE_RESET = 3'h0;
   localparam logic [4:0] FORCE_RESET = 5'h00;

   // Trim limits and highest legal range code
   localparam logic [5:0] TRIM_MAX        = 6'h1f;
   localparam logic [5:0] TRIM_MIN        = 6'h20;
   localparam logic [2:0] RANGE_MAX_CODE  = 3'h5;

   // Frequency figures
   localparam int BASE_FREQ_HZ   = 1_000_000;
   localparam int REF_FREQ_HZ    = 32_768;
   localparam int LOCK_TOL_PCT   = 1;
   localparam int STEP_BAND_PERMILLE = 5;

   // Settling time after a range change
   localparam int CLK_MHZ        = 100;
   localparam int SETTLE_TIME_NS = 10_000;
   localparam int SETTLE_CYCLES  = (SETTLE_TIME_NS * CLK_MHZ) / 1000;

   // Tuning window and oscillator tick divider
   localparam int WIN_REFS_DEF   = 256;
   localparam int TICK_DIV_DEF   = 16;
endpackage
`default_nettype wire

//--- verif/oct_ctrl_chk.sv
// Port-level assertion checker for the oscillator control block
`default_nettype none
module oct_ctrl_chk (
   input wire logic        clk_sys_in,
   input wire logic        sys_rst_in,
   input wire logic [11:0] addr_in,
   input wire logic [7:0]  wr_data_in,
   input wire logic        wr_en_in,
   input wire logic        rd_en_in,
   input wire logic [7:0]  rd_data_out,
   input wire logic [5:0]  freq_trim_field_out,
   input wire logic [2:0]  fast_osc_range_select_out,
   input wire logic [4:0]  force_on_out,
   input wire logic        secondary_osc_high_power_out,
   input wire logic        tuning_irq_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);
   // Strobes aimed at one register
   sequence rd_at(logic [11:0] a); rd_en_in && addr_in == a; endsequence
   sequence wr_at(logic [11:0] a); wr_en_in && addr_in == a; endsequence
   // Legal range write; reserved codes must leave no trace
   sequence rng_ok; wr_at(oct_pkg::ADDR_FREQ_SELECT) ##0 wr_data_in[2:0] <= 3'h5; endsequence

   AST_UNMAPPED:
      assert property (rd_en_in && !(addr_in inside {[12'h20e:12'h217]}) |=> rd_data_out == 8'h00)
      else $error("unmapped read not zero");
   AST_TRIM_RD:
      assert property (rd_at(oct_pkg::ADDR_FREQ_TRIM) |=>
                       rd_data_out == {2'b00, $past(freq_trim_field_out)})
      else $error("trim readback wrong");
   AST_RNG_RD:
      assert property (rd_at(oct_pkg::ADDR_FREQ_SELECT) |=>
                       rd_data_out == {5'h00, $past(fast_osc_range_select_out)})
      else $error("range readback wrong");
   AST_FORCE_RD:
      assert property (rd_at(oct_pkg::ADDR_FORCE_ENABLE) |=>
                       rd_data_out == {1'b0, $past(force_on_out), 2'b00})
      else $error("force readback wrong");
   AST_PWR_RD:
      assert property (rd_at(oct_pkg::ADDR_SEC_POWER) |=>
                       rd_data_out == {1'b0, $past(secondary_osc_high_power_out), 6'h00})
      else $error("power readback wrong");
   AST_SRC_RD:
      assert property (rd_at(oct_pkg::ADDR_SRC_READBACK) |=>
                       rd_data_out[7] == 1'b0 && rd_data_out[3:0] == 4'h0)
      else $error("source readback has stray bits");
   AST_IRQ_FLAG:
      assert property (tuning_irq_out && rd_en_in && addr_in == oct_pkg::ADDR_IRQ_STATUS |=>
                       rd_data_out == 8'h01)
      else $error("irq high without event flag");
   AST_TRIM_HOLD:
      assert property (wr_at(oct_pkg::ADDR_TUNING_CTRL) ##0 wr_data_in[6] ##1
                       wr_at(oct_pkg::ADDR_FREQ_TRIM) |=> $stable(freq_trim_field_out))
      else $error("trim write passed while held");
   AST_RNG_WR:
      assert property (rng_ok |=> fast_osc_range_select_out == $past(wr_data_in[2:0]))
      else $error("range write not applied");
   AST_RNG_RSV:
      assert property (wr_at(oct_pkg::ADDR_FREQ_SELECT) ##0 wr_data_in[2:0] > 3'h5 |=>
                       $stable(fast_osc_range_select_out))
      else $error("reserved range code applied");
   AST_RDY_CLR:
      assert property (rng_ok ##1 rd_at(oct_pkg::ADDR_READY_FLAGS) |=> rd_data_out[6] == 1'b0)
      else $error("fast ready not cleared");
endmodule

bind oct_ctrl oct_ctrl_chk u_oct_ctrl_chk (
   .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
   .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
   .freq_trim_field_out(freq_trim_field_out),
   .fast_osc_range_select_out(fast_osc_range_select_out), .force_on_out(force_on_out),
   .secondary_osc_high_power_out(secondary_osc_high_power_out),
   .tuning_irq_out(tuning_irq_out));
`default_nettype wire

//--- verif/oct_ctrl_test.sv
// Self-checking testbench for the oscillator control block
`default_nettype none
module oct_ctrl_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int LIMIT = 60000;
   logic        clk_sys_in = 1'b0;
   logic        sys_rst_in = 1'b1;
   logic [11:0] addr_in = 12'h000;
   logic [7:0]  wr_data_in = 8'h00;
   logic        wr_en_in = 1'b0;
   logic        rd_en_in = 1'b0;
   logic [7:0]  rd_data_out;
   logic        ref_clk = 1'b0;
   logic        tick = 1'b0;
   logic [5:0]  rdy = 6'h00;
   logic [2:0]  src = 3'h0;
   logic [5:0]  trim;
   logic [2:0]  rng;
   logic [4:0]  force_on;
   logic        hp;
   logic        irq;
   logic [7:0]  got;
   logic [31:0] r;
   logic [5:0]  e_trim = 6'h00;
   logic [2:0]  e_rng = 3'h0;
   logic [4:0]  e_force = 5'h00;
   logic        e_pwr = 1'b0;
   logic        e_hold = 1'b0;
   logic [11:0] regs [4] = '{12'h20f, 12'h211, 12'h212, 12'h213};
   int mismatches = 0;
   int comparisons = 0;
   int cycles = 0;
   int seed = 32'h8d2f;
   int ref_cnt = 0;
   int tick_cnt = 0;
   int tick_half = 5;

   oct_ctrl #(.WIN_REFS(4), .TICK_DIV(16), .SETTLE_CYCLES(8)) u_oct_ctrl (
      .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
      .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
      .rd_data_out(rd_data_out), .ref_clk_in(ref_clk), .fast_osc_tick_in(tick),
      .osc_ready_in(rdy), .current_source_code_in(src), .freq_trim_field_out(trim),
      .fast_osc_range_select_out(rng), .force_on_out(force_on),
      .secondary_osc_high_power_out(hp), .tuning_irq_out(irq));

   always #5 clk_sys_in = ~clk_sys_in;

   // Reference every 610 cycles; tick period 2*tick_half, so 10 gives an exact match
   always @(posedge clk_sys_in)
   begin
      ref_cnt <= (ref_cnt == 304) ? 0 : ref_cnt + 1;
      ref_clk <= (ref_cnt == 304) ? ~ref_clk : ref_clk;
      tick_cnt <= (tick_cnt >= tick_half - 1) ? 0 : tick_cnt + 1;
      tick <= (tick_cnt >= tick_half - 1) ? ~tick : tick;
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         mismatches++;
         conclude();
      end
   end

   task automatic conclude;
      $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic cmp(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e)
      begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // One bus cycle; signals change only right after the edge
   task automatic bus(input logic w, input logic rd, input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_sys_in);
      wr_en_in <= w;
      rd_en_in <= rd;
      addr_in <= a;
      wr_data_in <= d;
   endtask

   // Idle edge lets the last request land before anything is sampled
   task automatic idle;
      bus(1'b0, 1'b0, addr_in, 8'h00);
      #1;
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      bus(1'b1, 1'b0, a, d);
      idle();
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
      bus(1'b0, 1'b1, a, 8'h00);
      idle();
      got = rd_data_out;
      cmp(got, e);
   endtask

   // Poll a register until masked bits match; bounded
   task automatic wait_reg(input logic [11:0] a, input logic [7:0] m, input logic [7:0] v);
      for (int i = 0; i < 60; i++)
      begin
         bus(1'b0, 1'b1, a, 8'h00);
         idle();
         if ((rd_data_out & m) === v)
            break;
         repeat (150) @(posedge clk_sys_in);
      end
      cmp(rd_data_out & m, v);
   endtask

   function automatic logic [7:0] rst_val(input logic [11:0] a);
      case (a)
         12'h20e: return {1'b0, src, 4'h0};
         12'h210: return {1'b0, rdy, 1'b0};
         default: return 8'h00;
      endcase
   endfunction

   initial
   begin
      // Fast ready held high so its clear after a range write is visible
      @(posedge clk_sys_in);
      rdy <= 6'($random(seed)) | 6'h20;
      src <= 3'($random(seed));
      repeat (7) @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
      // Writes to read-only and unmapped places must vanish
      wr(12'h20e, 8'hff);
      wr(12'h210, 8'hff);
      wr(12'h218, 8'hff);
      for (int a = 32'h20e; a <= 32'h218; a++)
         rd_chk(12'(a), rst_val(12'(a)));
      // Random register traffic; trim writes sometimes follow a hold write back to back
      for (int n = 0; n < 40; n++)
      begin
         r = $random(seed);
         if (r[9:8] == 2'd2)
            e_hold = r[16];
         if (r[9:8] == 2'd2)
            bus(1'b1, 1'b0, oct_pkg::ADDR_TUNING_CTRL, {1'b0, r[16], 6'h00});
         bus(1'b1, 1'b0, regs[r[9:8]], r[7:0]);
         case (r[9:8])
            2'd0: e_pwr = r[6];
            2'd1: e_force = r[6:2];
            2'd2: e_trim = e_hold ? e_trim : r[5:0];
            default: e_rng = (r[2:0] > 3'h5) ? e_rng : r[2:0];
         endcase
         if (r[9:8] == 2'd3 && r[2:0] <= 3'h5)
            rd_chk(oct_pkg::ADDR_READY_FLAGS, {2'b00, rdy[4:0], 1'b0});
         else
            idle();
         cmp({2'b00, trim}, {2'b00, e_trim});
         cmp({5'h00, rng}, {5'h00, e_rng});
         cmp({2'b00, force_on, hp}, {2'b00, e_force, e_pwr});
      end
      repeat (12) @(posedge clk_sys_in);
      rd_chk(12'h20f, {1'b0, e_pwr, 6'h00});
      rd_chk(12'h211, {1'b0, e_force, 2'b00});
      rd_chk(12'h212, {2'b00, e_trim});
      rd_chk(12'h213, {5'h00, e_rng});
      rd_chk(12'h214, {1'b0, e_hold, 6'h00});
      rd_chk(12'h210, {1'b0, rdy, 1'b0});
      // Tuning from the lowest trim with a fast oscillator runs out of range
      wr(oct_pkg::ADDR_TUNING_CTRL, 8'h00);
      wr(oct_pkg::ADDR_FREQ_TRIM, 8'h20);
      wr(oct_pkg::ADDR_FREQ_SELECT, 8'h05);
      wr(oct_pkg::ADDR_IRQ_ENABLE, 8'h01);
      tick_half = 4;
      wr(oct_pkg::ADDR_TUNING_CTRL, 8'h80);
      wr(oct_pkg::ADDR_FREQ_TRIM, 8'h05);
      wait_reg(oct_pkg::ADDR_TUNING_CTRL, 8'h8a, 8'h82);
      cmp({2'b00, trim}, 8'h20);
      rd_chk(oct_pkg::ADDR_IRQ_STATUS, 8'h01);
      cmp({7'h00, irq}, 8'h01);
      wr(oct_pkg::ADDR_IRQ_CLEAR, 8'h01);
      cmp({7'h00, irq}, 8'h00);
      // Exact frequency: lock set, out-of-range cleared, event again
      tick_half = 5;
      wait_reg(oct_pkg::ADDR_TUNING_CTRL, 8'h8a, 8'h88);
      cmp({7'h00, irq}, 8'h01);
      wr(oct_pkg::ADDR_IRQ_ENABLE, 8'h00);
      rd_chk(oct_pkg::ADDR_IRQ_STATUS, 8'h01);
      cmp({7'h00, irq}, 8'h00);
      // Hold freezes engine updates of a slow oscillator until released
      bus(1'b1, 1'b0, oct_pkg::ADDR_TUNING_CTRL, 8'hc0);
      bus(1'b1, 1'b0, oct_pkg::ADDR_FREQ_TRIM, 8'h11);
      idle();
      tick_half = 6;
      repeat (6000) @(posedge clk_sys_in);
      cmp({2'b00, trim}, 8'h20);
      wr(oct_pkg::ADDR_TUNING_CTRL, 8'h80);
      for (int i = 0; i < 8000 && trim === 6'h20; i++)
         @(posedge clk_sys_in);
      #1;
      cmp({2'b00, trim}, 8'h21);
      // Disabling hands the trim back to software
      wr(oct_pkg::ADDR_TUNING_CTRL, 8'h00);
      rd_chk(oct_pkg::ADDR_TUNING_CTRL, 8'h00);
      wr(oct_pkg::ADDR_FREQ_TRIM, 8'h15);
      cmp({2'b00, trim}, 8'h15);
      conclude();
   end
endmodule
`default_nettype wire
